// >>> core/pfs_consts.svh
// pfs_consts.svh: constants for the pin function select block
// assumes: included by pfs_pkg and by the core modules
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH
`define PFS_NUM_PINS      33
`define PFS_NUM_ALTS      5
`define PFS_NUM_SEG       29
`define PFS_NUM_SEG_SHARE 23
`define PFS_DBG_BIT_CYC   16
`define PFS_RST_PIN_IDX   6'h0B
`define PFS_DBG_PIN_IDX   6'h12
`define PFS_SEL_PORT      3'h0
`endif

// >>> core/pfs_pkg.sv
// pfs_pkg.sv: types shared by the pin function select block
// assumes: pfs_consts.svh defines the widths
`include "pfs_consts.svh"
package pfs_pkg;
  // one pin's output-side settings, from the port or a peripheral
  typedef struct packed {
    logic out;       // data driven
    logic oe;        // output enable
    logic pull_en;   // pull-up request when input
    logic drive_hi;  // high drive strength
    logic slew_en;   // slew limiter on
  } pfs_pad_ctl_t;
  // mode at the release of reset
  typedef enum logic {PFS_MODE_NORMAL, PFS_MODE_BACKGROUND} pfs_mode_t;
endpackage

// >>> core/pfs_pin_arb.sv
// pfs_pin_arb.sv: priority selection for one shared pin
// assumes: requests from port and five alternates arrive as structs
`timescale 1ns/1ns
`include "pfs_consts.svh"
module pfs_pin_arb
  import pfs_pkg::*;
(
  input  wire logic [`PFS_NUM_ALTS-1:0] alt_en_i,  // alternate enables, bit 4 highest
  input  wire pfs_pad_ctl_t             port_i,    // port settings
  input  wire pfs_pad_ctl_t             alt1_i,
  input  wire pfs_pad_ctl_t             alt2_i,
  input  wire pfs_pad_ctl_t             alt3_i,
  input  wire pfs_pad_ctl_t             alt4_i,
  input  wire pfs_pad_ctl_t             alt5_i,
  output pfs_pad_ctl_t                  pad_o,     // winning settings
  output logic [2:0]                    sel_o      // 0 port, n alt n
);
  // highest enabled alternate wins, else the port alone drives
  always_comb begin
    pad_o = port_i;  // RULE_17
    sel_o = `PFS_SEL_PORT;
    if (alt_en_i[4]) begin  // RULE_13
      pad_o = alt5_i;
      sel_o = 3'h5;
    end else if (alt_en_i[3]) begin
      pad_o = alt4_i;
      sel_o = 3'h4;
    end else if (alt_en_i[2]) begin
      pad_o = alt3_i;
      sel_o = 3'h3;
    end else if (alt_en_i[1]) begin
      pad_o = alt2_i;
      sel_o = 3'h2;
    end else if (alt_en_i[0]) begin
      pad_o = alt1_i;
      sel_o = 3'h1;
    end
  end
endmodule

// >>> core/pfs_top.sv
// pfs_top.sv: pin function select and reset-time pin configuration
// assumes: one bus clock, pads outside resolve oe/out into levels
// What the document requires
// RULE_01: reset pin is input port after power-on
// RULE_02: enable bit makes it reset until reset
// RULE_03: reset role enables pull-up, low resets
// RULE_04: debug pin low at reset release: background
// RULE_05: after reset debug pin: pull-up, no slew
// RULE_06: every reset sets the debug pin enable
// RULE_07: debug bit time is sixteen controller cycles
// RULE_08: debug pin pseudo open-drain with speed-ups
// RULE_09: 29 segment pins, Hi-Z, port by default
// RULE_10: 33 port pins shared with peripherals
// RULE_11: drive strength, slew, pull-up per pin
// RULE_12: after reset pins are Hi-Z, no pull-up
// RULE_13: highest enabled alternate function owns pin
// RULE_14: software clears flags before enabling interrupts
// RULE_15: software disables sharers before enabling another
// RULE_16: reset pin input only, debug pin output only
// RULE_17: no alternate enabled: port settings rule
`timescale 1ns/1ns
`include "pfs_consts.svh"
module pfs_top
  import pfs_pkg::*;
(
  input  wire logic                          clk_sys_i,
  input  wire logic                          reset_i,          // any reset source
  // software option bits
  input  wire logic                          reset_pin_enable_set_i, // write 1 pulse
  input  wire logic                          debug_pin_enable_clr_i, // write 0 pulse
  // port settings and peripheral requests per pin
  input  wire pfs_pad_ctl_t [`PFS_NUM_PINS-1:0] port_ctl_i,
  input  wire pfs_pad_ctl_t [`PFS_NUM_PINS-1:0] alt1_ctl_i,
  input  wire pfs_pad_ctl_t [`PFS_NUM_PINS-1:0] alt2_ctl_i,
  input  wire pfs_pad_ctl_t [`PFS_NUM_PINS-1:0] alt3_ctl_i,
  input  wire pfs_pad_ctl_t [`PFS_NUM_PINS-1:0] alt4_ctl_i,
  input  wire pfs_pad_ctl_t [`PFS_NUM_PINS-1:0] alt5_ctl_i,
  input  wire logic [`PFS_NUM_PINS-1:0][`PFS_NUM_ALTS-1:0] alt_en_i,
  // segment pins that have no port behind them
  input  wire logic [`PFS_NUM_SEG-`PFS_NUM_SEG_SHARE-1:0] seg_only_en_i,
  input  wire logic [`PFS_NUM_SEG-`PFS_NUM_SEG_SHARE-1:0] seg_only_out_i,
  // pads
  input  wire logic [`PFS_NUM_PINS-1:0]      pad_in_i,
  output logic [`PFS_NUM_PINS-1:0]           pad_out_o,
  output logic [`PFS_NUM_PINS-1:0]           pad_oe_o,
  output logic [`PFS_NUM_PINS-1:0]           pad_pull_o,
  output logic [`PFS_NUM_PINS-1:0]           pad_drive_hi_o,
  output logic [`PFS_NUM_PINS-1:0]           pad_slew_o,
  output logic [`PFS_NUM_SEG-`PFS_NUM_SEG_SHARE-1:0] seg_out_o,
  output logic [`PFS_NUM_SEG-`PFS_NUM_SEG_SHARE-1:0] seg_oe_o,
  // debug controller side of the background debug pin
  input  wire logic                          debug_drive_low_i, // pull line low
  input  wire logic                          debug_speedup_i,   // brief high drive
  output logic                               debug_line_o,      // line level straight from the pad, unregistered
  // status
  output logic                               reset_pin_enable_o,
  output logic                               debug_pin_enable_o,
  output pfs_mode_t                          mode_o,
  output logic                               ext_reset_req_o,  // ask system to reset
  output logic [`PFS_NUM_PINS-1:0][2:0]      pin_sel_o
);
  localparam int NP = `PFS_NUM_PINS;
  localparam int NS = `PFS_NUM_SEG - `PFS_NUM_SEG_SHARE;

  logic       rst_en_r,  rst_en_nxt;   // shared reset pin is reset input
  logic       dbg_en_r,  dbg_en_nxt;   // debug pin owns the shared pin
  logic       first_r,   first_nxt;    // first clock after release
  pfs_mode_t  mode_r,    mode_nxt;     // mode caught at release
  pfs_pad_ctl_t [NP-1:0] arb_pad;      // arbiter winners
  pfs_pad_ctl_t [NP-1:0] pad_nxt;      // final pad settings
  pfs_pad_ctl_t [NP-1:0] pad_r;        // registered pad settings
  logic [NP-1:0][2:0]    sel_w;        // arbiter selections
  logic [NS-1:0]         seg_out_r, seg_oe_r;

  // per-pin priority selection
  genvar g;
  generate
    for (g = 0; g < NP; g = g + 1) begin : g_arb
      pfs_pin_arb u_arb (
        .alt_en_i (alt_en_i[g]),
        .port_i   (port_ctl_i[g]),
        .alt1_i   (alt1_ctl_i[g]),
        .alt2_i   (alt2_ctl_i[g]),
        .alt3_i   (alt3_ctl_i[g]),
        .alt4_i   (alt4_ctl_i[g]),
        .alt5_i   (alt5_ctl_i[g]),
        .pad_o    (arb_pad[g]),
        .sel_o    (sel_w[g])
      );
    end
  endgenerate

  // option bits and the mode strap; no set/clear conflict since both are one-shot writes
  always_comb begin
    rst_en_nxt = rst_en_r | reset_pin_enable_set_i;            // RULE_02
    dbg_en_nxt = dbg_en_r & ~debug_pin_enable_clr_i;
    first_nxt  = 1'b0;
    mode_nxt   = mode_r;
    if (first_r) begin
      // caught by a clocked process after release, never by the reset itself
      mode_nxt = pad_in_i[`PFS_DBG_PIN_IDX] ? PFS_MODE_NORMAL
                                            : PFS_MODE_BACKGROUND; // RULE_04
    end
  end

  // option register; every reset sets debug enable and clears reset enable
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rst_en_r <= 1'b0;  // RULE_01
      dbg_en_r <= 1'b1;  // RULE_06
      first_r  <= 1'b1;
      mode_r   <= PFS_MODE_NORMAL;
    end else begin
      rst_en_r <= rst_en_nxt;
      dbg_en_r <= dbg_en_nxt;
      first_r  <= first_nxt;
      mode_r   <= mode_nxt;
    end
  end

  // final pad settings with the two special pins overriding arbitration
  always_comb begin
    pad_nxt = arb_pad;
    for (int i = 0; i < NP; i++) begin
      pad_nxt[i].oe = arb_pad[i].oe;                           // RULE_11
    end
    // shared reset pin: input only as port, pulled up as reset
    pad_nxt[`PFS_RST_PIN_IDX].oe      = 1'b0;                  // RULE_16
    pad_nxt[`PFS_RST_PIN_IDX].pull_en = rst_en_r |
                                        arb_pad[`PFS_RST_PIN_IDX].pull_en; // RULE_03
    if (dbg_en_r) begin
      // pseudo open-drain: drive low, or drive high only for the speed-up
      pad_nxt[`PFS_DBG_PIN_IDX].oe       = debug_drive_low_i | debug_speedup_i; // RULE_08
      pad_nxt[`PFS_DBG_PIN_IDX].out      = debug_speedup_i & ~debug_drive_low_i;
      pad_nxt[`PFS_DBG_PIN_IDX].pull_en  = 1'b1;               // RULE_05
      pad_nxt[`PFS_DBG_PIN_IDX].drive_hi = 1'b0;
      pad_nxt[`PFS_DBG_PIN_IDX].slew_en  = 1'b0;
    end else begin
      pad_nxt[`PFS_DBG_PIN_IDX].oe = 1'b1;                     // RULE_16
    end
  end

  // pad registers; reset leaves every pin a floating input
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      pad_r     <= '0;   // RULE_12 RULE_09
      seg_out_r <= '0;
      seg_oe_r  <= '0;
    end else begin
      pad_r     <= pad_nxt;  // RULE_10
      seg_out_r <= seg_only_out_i;
      seg_oe_r  <= seg_only_en_i;
    end
  end

  // outputs; the debug line is combinational so bit timing (RULE_07) stays
  // with the controller, which may run at bus rate
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      pad_out_o[i]      = pad_r[i].out;
      pad_oe_o[i]       = pad_r[i].oe;
      pad_pull_o[i]     = pad_r[i].pull_en;
      pad_drive_hi_o[i] = pad_r[i].drive_hi;
      pad_slew_o[i]     = pad_r[i].slew_en;
    end
  end
  assign seg_out_o          = seg_out_r;
  assign seg_oe_o           = seg_oe_r;
  assign debug_line_o       = pad_in_i[`PFS_DBG_PIN_IDX];      // RULE_07
  assign reset_pin_enable_o = rst_en_r;
  assign debug_pin_enable_o = dbg_en_r;
  assign mode_o             = mode_r;
  assign ext_reset_req_o    = rst_en_r & ~pad_in_i[`PFS_RST_PIN_IDX]; // RULE_03
  assign pin_sel_o          = sel_w;

  // reset-pin enable, once set, stays until reset
  property p_rst_sticky;
    @(posedge clk_sys_i) disable iff (reset_i) rst_en_r |=> rst_en_r;
  endproperty
  a_rst_sticky: assert property (p_rst_sticky) else $error("reset pin enable dropped"); // RULE_02

  property p_rst_pull;
    @(posedge clk_sys_i) disable iff (reset_i)
      rst_en_r |=> pad_pull_o[`PFS_RST_PIN_IDX];
  endproperty
  a_rst_pull: assert property (p_rst_pull) else $error("reset pin pull-up off"); // RULE_03

  property p_rst_in_only;
    @(posedge clk_sys_i) disable iff (reset_i) !pad_oe_o[`PFS_RST_PIN_IDX];
  endproperty
  a_rst_in_only: assert property (p_rst_in_only) else $error("reset pin driven"); // RULE_16

  property p_mode_strap;
    @(posedge clk_sys_i) disable iff (reset_i)
      first_r && !pad_in_i[`PFS_DBG_PIN_IDX] |=> mode_o == PFS_MODE_BACKGROUND;
  endproperty
  a_mode_strap: assert property (p_mode_strap) else $error("strap not caught"); // RULE_04

  property p_dbg_pad;
    @(posedge clk_sys_i) disable iff (reset_i)
      dbg_en_r ##1 dbg_en_r |-> pad_pull_o[`PFS_DBG_PIN_IDX] && !pad_slew_o[`PFS_DBG_PIN_IDX];
  endproperty
  a_dbg_pad: assert property (p_dbg_pad) else $error("debug pad settings wrong"); // RULE_05

  property p_dbg_od;
    @(posedge clk_sys_i) disable iff (reset_i)
      dbg_en_r && !debug_speedup_i && debug_drive_low_i |=> pad_oe_o[`PFS_DBG_PIN_IDX]
        && !pad_out_o[`PFS_DBG_PIN_IDX];
  endproperty
  a_dbg_od: assert property (p_dbg_od) else $error("debug pin not pulled low"); // RULE_08

  property p_prio;
    @(posedge clk_sys_i) disable iff (reset_i)
      alt_en_i[0][4] |-> pin_sel_o[0] == 3'h5;
  endproperty
  a_prio: assert property (p_prio) else $error("priority lost"); // RULE_13

  property p_port_only;
    @(posedge clk_sys_i) disable iff (reset_i)
      alt_en_i[1] == '0 |=> pad_oe_o[1] == $past(port_ctl_i[1].oe);
  endproperty
  a_port_only: assert property (p_port_only) else $error("port not in control"); // RULE_17
endmodule

// >>> test/pfs_dbg_pod.sv
// pfs_dbg_pod.sv: debug pod and external reset source seen at the pins
// assumes: the device pad enables say when the device drives a line
`timescale 1ns/1ns
module pfs_dbg_pod (
  input  wire logic clk_i,
  input  wire logic dbg_oe_i,    // device drives the debug line
  input  wire logic dbg_out_i,   // device level on the debug line
  input  wire logic strap_low_i, // pod holds the debug line low
  input  wire logic rst_low_i,   // external source pulls reset pin low
  input  wire logic rst_pull_i,  // device pull-up on the reset pin
  output logic      dbg_line_o,
  output logic      rst_line_o
);
  logic float_r = 1'h0; // unpulled floating pin wanders, never a stale level
  // toggles every cycle so an undriven pin cannot pass by luck
  always @(posedge clk_i) begin
    float_r <= ~float_r;
  end
  // pod only pulls low; an undriven debug line reads high, an unpulled reset line toggles
  assign dbg_line_o = dbg_oe_i ? dbg_out_i : ~strap_low_i;
  assign rst_line_o = rst_low_i ? 1'h0 : (rst_pull_i ? 1'h1 : float_r);
endmodule

// >>> test/testbench.sv
// testbench.sv: directed checks of the pin function select block
// assumes: pfs_pkg compiled first, pod model drives pins 11 and 18
`timescale 1ns/1ns
module testbench import pfs_pkg::*;;
  logic                clk_sys_i = 1'h0;
  logic                reset_i;     // raised by the first reset call at time zero
  logic                rpe_set, dpe_clr, dbg_low, dbg_up, strap_low, rst_low;
  pfs_pad_ctl_t [32:0] ctl [0:5];   // port then alternates one to five
  logic [32:0][4:0]    en;          // alternate enables per pin
  logic [5:0]          seg_en, seg_d, s_out, s_oe;
  logic [32:0]         pin, p_out, p_oe, p_pull, p_drv, p_slew;
  logic                line, rpe, dpe, rreq, dline, rline;
  pfs_mode_t           mode;
  logic [32:0][2:0]    sel;
  int                  err_total  = 0;
  int                  n_compared = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  // other pins loop the device output back as their level
  assign pin = {p_out[32:19], dline, p_out[17:12], rline, p_out[10:0]};
  pfs_dbg_pod u_pod (.clk_i(clk_sys_i), .dbg_oe_i(p_oe[18]), .dbg_out_i(p_out[18]),
    .strap_low_i(strap_low), .rst_low_i(rst_low), .rst_pull_i(p_pull[11]),
    .dbg_line_o(dline), .rst_line_o(rline));
  pfs_top u_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .reset_pin_enable_set_i(rpe_set), .debug_pin_enable_clr_i(dpe_clr),
    .port_ctl_i(ctl[0]), .alt1_ctl_i(ctl[1]), .alt2_ctl_i(ctl[2]), .alt3_ctl_i(ctl[3]),
    .alt4_ctl_i(ctl[4]), .alt5_ctl_i(ctl[5]), .alt_en_i(en), .seg_only_en_i(seg_en),
    .seg_only_out_i(seg_d), .pad_in_i(pin), .pad_out_o(p_out), .pad_oe_o(p_oe),
    .pad_pull_o(p_pull), .pad_drive_hi_o(p_drv), .pad_slew_o(p_slew), .seg_out_o(s_out),
    .seg_oe_o(s_oe), .debug_drive_low_i(dbg_low), .debug_speedup_i(dbg_up),
    .debug_line_o(line), .reset_pin_enable_o(rpe), .debug_pin_enable_o(dpe),
    .mode_o(mode), .ext_reset_req_o(rreq), .pin_sel_o(sel));
  // inputs move on falling edges, so checks see settled outputs
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // reset with the strap held or released across the rising edge
  task automatic do_reset(input logic low);
    strap_low = low;
    reset_i = 1'h1;
    tick(3);
    chk(p_oe, 40'h0);
    chk(p_pull, 40'h0);
    chk({s_oe, rpe, dpe}, 40'h1);
    reset_i = 1'h0;
    tick(3);
    strap_low = 1'h0;
  endtask
  // each source gets its own code so the winner is recognisable
  task automatic prio(input logic [2:0] k);
    ctl[k][0] = {k[0], 1'h1, 1'h0, k[1], k[2]};
    if (k != 3'h0) begin
      // no interrupt flags modelled here, so nothing to clear before enabling
      en[0][k-3'h1] = 1'h1;
    end
    tick(1);
    chk({sel[0], p_out[0], p_oe[0], p_drv[0], p_slew[0]}, {k, k[0], 1'h1, k[1], k[2]});
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // watchdog: the run needs under a microsecond and a half
  initial begin
    #100000;
    err_total++;
    end_of_test();
  end
  initial begin
    {rpe_set, dpe_clr, dbg_low, dbg_up, rst_low} = 5'h0;
    for (int i = 0; i < 6; i++) ctl[i] = '0;
    en = '0;
    seg_en = 6'h0;
    seg_d = 6'h0;
    do_reset(1'h1);
    chk(mode, PFS_MODE_BACKGROUND);
    chk({p_pull[18], p_slew[18]}, 40'h2);
    dbg_low = 1'h1;
    tick(1);
    chk({p_oe[18], p_out[18], line}, 40'h4);
    dbg_low = 1'h0;
    dbg_up = 1'h1;
    tick(1);
    chk({p_oe[18], p_out[18], line}, 40'h7);
    dbg_up = 1'h0;
    // shared reset pin: an input port until enabled; port pull left off so
    // the pull-up seen later can only come from the reset role
    rst_low = 1'h1;
    ctl[0][11] = 5'h1B;
    tick(1);
    chk({rreq, p_oe[11], p_pull[11]}, 40'h0);
    rpe_set = 1'h1;
    tick(1);
    rpe_set = 1'h0;
    chk(rpe, 40'h1);
    tick(1);
    chk({p_pull[11], rreq}, 40'h3);
    rst_low = 1'h0;
    tick(1);
    chk(rreq, 40'h0);
    // climb the priority ladder on pin 0, lower sharers left on
    for (int k = 0; k < 6; k++) prio(k[2:0]);
    en = '0;
    ctl[0][0] = 5'h04;
    ctl[0][1] = 5'h0A;
    tick(1);
    chk({sel[0], p_oe[0], p_pull[0], p_oe[1], p_drv[1]}, 40'h7);
    // output-only port bit after the debug role is released
    ctl[0][18] = 5'h10;
    dpe_clr = 1'h1;
    tick(1);
    dpe_clr = 1'h0;
    chk(dpe, 40'h0);
    tick(1);
    chk({p_oe[18], p_out[18]}, 40'h3);
    seg_en = 6'h3F;
    seg_d = 6'h2A;
    tick(2);
    chk({s_oe, s_out}, 40'hFEA);
    do_reset(1'h0);
    chk(mode, PFS_MODE_NORMAL);
    chk({rpe, dpe}, 40'h1);
    end_of_test();
  end
endmodule
